// ---- dv/fir_cmd_reader_test.sv ----
// Self-checking bench of the identity and register read block.
`timescale 1ns/100ps
`default_nettype none
module fir_cmd_reader_test;
  // Identity values handed to the device; these values are arbitrary.
  localparam logic [7:0] MK = 8'h96;
  localparam logic [15:0] PT = 16'h7e21;
  localparam logic [63:0] SN = 64'hfeed_0bad_1357_2468;
  logic mclk, sys_rst, cs_n, sck, pcfg3_load, ptab_valid, ptab_ready, took;
  logic [3:0] io_in, io_out, io_oe_n;
  logic [7:0] regs [0:4];
  logic [7:0] pcfg3_data, persistent_config_three, ptab_data;
  logic [31:0] ptab_addr;
  int errors, checks_done;
  logic [7:0] codes [0:4] = '{fir_pkg::CMD_ST1, fir_pkg::CMD_ST2, fir_pkg::CMD_CF1, fir_pkg::CMD_CF2,
                              fir_pkg::CMD_CF3};

  ////////////////////////////////////////////////////////////////
  // Device and host model.
  fir_cmd_reader #(.MAKER_ID(MK), .PART_ID(PT), .UNIQUE_SERIAL(SN)) i_fir_cmd_reader (
    .mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .volatile_status_one(regs[0]), .volatile_status_two(regs[1]),
    .volatile_config_one(regs[2]), .volatile_config_two(regs[3]), .volatile_config_three(regs[4]),
    .pcfg3_load(pcfg3_load), .pcfg3_data(pcfg3_data), .persistent_config_three(persistent_config_three),
    .ptab_addr(ptab_addr), .ptab_valid(ptab_valid), .ptab_ready(ptab_ready), .ptab_data(ptab_data));
  fir_host i_fir_host (.mclk(mclk), .cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n));

  // Clock of 20 ns.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Table source stalls a cycle after every take, so the buffer sees gaps.
  always @(posedge mclk) took <= ptab_valid && ptab_ready;
  always @(negedge mclk) begin
    ptab_valid <= !took;
    ptab_data <= ptab_addr[7:0] ^ 8'ha5;
  end

  ////////////////////////////////////////////////////////////////
  // Comparison and frame-end helpers.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic fin(input logic [3:0] oe);
    chk(i_fir_host.oe_seen, oe);
    chk(io_oe_n, fir_pkg::OE_OFF);
  endtask : fin

  task automatic close_out;
    $display("Compared %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_persist;
    chk(persistent_config_three, 8'h08);
    pcfg3_data = 8'h05;
    pcfg3_load = 1'b1;
    @(negedge mclk);
    pcfg3_load = 1'b0;
    @(negedge mclk);
    chk(persistent_config_three, 8'h05);
    $display("Test persist done");
  endtask : t_persist

  // Register reads stay single-line; a change mid-frame must show in byte two.
  task automatic t_regs;
    for (int i = 0; i < 5; i++) begin
      regs[i] = 8'h40 + 8'(i);
      fork
        i_fir_host.xfer(codes[i], 1'b0, 1'b0, 0, 32'h0, 0, 2);
        begin
          repeat (100) @(negedge mclk);
          regs[i] = regs[i] ^ 8'h30;
        end
      join
      chk(i_fir_host.got[0], 8'h40 + 8'(i));
      chk(i_fir_host.got[1], 8'h70 + 8'(i));
      fin(fir_pkg::OE_SINGLE);
      regs[i] = 8'h00;
    end
    $display("Test register reads done");
  endtask : t_regs

  task automatic t_qid;
    i_fir_host.xfer(fir_pkg::CMD_QUAD_ID, 1'b0, 1'b1, 0, 32'h0, 0, 2);
    fin(fir_pkg::OE_OFF);
    // A code outside the served set must also leave every line released.
    i_fir_host.xfer(8'hff, 1'b0, 1'b0, 0, 32'h0, 0, 1);
    fin(fir_pkg::OE_OFF);
    for (int m = 0; m < 2; m++) begin
      regs[2] = m ? 8'h00 : 8'h02;
      regs[3] = m ? 8'h08 : 8'h00;
      i_fir_host.xfer(fir_pkg::CMD_QUAD_ID, m[0], 1'b1, 0, 32'h0, 0, 3);
      chk(i_fir_host.got[0], MK);
      chk({i_fir_host.got[1], i_fir_host.got[2]}, PT);
      fin(fir_pkg::OE_QUAD);
    end
    // Four-line mode is still on, so the status byte must come back as two nibbles.
    regs[0] = 8'hc3;
    i_fir_host.xfer(fir_pkg::CMD_ST1, 1'b1, 1'b1, 0, 32'h0, 0, 1);
    chk(i_fir_host.got[0], 8'hc3);
    fin(fir_pkg::OE_QUAD);
    $display("Test quad identity done");
  endtask : t_qid

  // Starting address near a byte boundary checks the step into the next byte.
  task automatic t_ptab;
    regs[2] = 8'h00;
    regs[3] = 8'h00;
    regs[4] = 8'h08;
    i_fir_host.xfer(fir_pkg::CMD_PTAB, 1'b0, 1'b0, 3, 32'h0012_34fe, 8, 3);
    for (int i = 0; i < 3; i++) chk(i_fir_host.got[i], 8'((8'hfe + 8'(i)) ^ 8'ha5));
    fin(fir_pkg::OE_SINGLE);
    regs[3] = 8'h09;
    regs[4] = 8'h02;
    i_fir_host.xfer(fir_pkg::CMD_PTAB, 1'b1, 1'b1, 4, 32'h0000_0110, 2, 3);
    for (int i = 0; i < 3; i++) chk(i_fir_host.got[i], (8'h10 + 8'(i)) ^ 8'ha5);
    fin(fir_pkg::OE_QUAD);
    $display("Test parameter table done");
  endtask : t_ptab

  task automatic t_uid;
    for (int m = 0; m < 2; m++) begin
      regs[3] = m ? 8'h08 : 8'h00;
      regs[4] = 8'h00;
      i_fir_host.xfer(fir_pkg::CMD_UID, m[0], m[0], 0, 32'h0, 32, 8);
      for (int i = 0; i < 8; i++) chk(i_fir_host.got[i], SN[63 - 8*i -: 8]);
      fin(m ? fir_pkg::OE_QUAD : fir_pkg::OE_SINGLE);
    end
    $display("Test unique serial done");
  endtask : t_uid

  ////////////////////////////////////////////////////////////////
  // Main sequence: reset for 20 clocks, then every scenario.
  initial begin
    errors = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    pcfg3_load = 1'b0;
    pcfg3_data = 8'h00;
    took = 1'b0;
    ptab_valid = 1'b0;
    ptab_data = 8'h00;
    foreach (regs[i]) regs[i] = 8'h00;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_persist;
    t_regs;
    t_qid;
    t_ptab;
    t_uid;
    close_out;
  end

  // A hang counts as a mismatch and ends the run.
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    close_out;
  end
endmodule : fir_cmd_reader_test
`default_nettype wire

// ---- dv/fir_host.sv ----
// Host-side link controller model that frames commands toward the read block.
`timescale 1ns/100ps
`default_nettype none
module fir_host (
  // Clock.
  input wire logic mclk,
  // Link pins.
  output logic cs_n,
  output logic sck,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n
);
  logic [7:0] got [0:7];
  logic [3:0] oe_seen;

  ////////////////////////////////////////////////////////////////
  // Link idles deselected with its clock standing low.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io_in = 4'h0;
    oe_seen = 4'hf;
  end

  // One link clock of eight mclk, so the rate stays far below every limit.
  task automatic cyc(input logic [3:0] d, output logic [3:0] o);
    io_in = d;
    sck = 1'b0;
    repeat (4) @(negedge mclk);
    sck = 1'b1;
    repeat (4) @(negedge mclk);
    // Lines the device has released read inverted, so a held stale level never passes as data.
    o = io_out ^ io_oe_n;
  endtask : cyc

  // Sends a byte MSB first on line zero or as two nibbles.
  task automatic put(input logic [7:0] b, input logic q);
    logic [3:0] o;
    if (q) begin
      cyc(b[7:4], o);
      cyc(b[3:0], o);
    end else begin
      for (int i = 7; i >= 0; i--) cyc({3'b000, b[i]}, o);
    end
  endtask : put

  // Collects a byte; lines we do not own flip so stale values never pass.
  task automatic get(input logic q, output logic [7:0] b);
    logic [3:0] o;
    b = 8'h00;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      cyc(~io_in, o);
      b = q ? {b[3:0], o} : {b[6:0], o[1]};
      oe_seen = io_oe_n;
    end
  endtask : get

  // Whole frame: code, address bytes, dummy clocks, then n data bytes.
  task automatic xfer(input logic [7:0] c, input logic qc, input logic qd, input int na, input logic [31:0] a,
                      input int nd, input int n);
    logic [3:0] o;
    oe_seen = 4'hf;
    cs_n = 1'b0;
    repeat (2) @(negedge mclk);
    put(c, qc);
    for (int i = na - 1; i >= 0; i--) put(a[8*i +: 8], qd);
    repeat (nd) cyc(~io_in, o);
    for (int i = 0; i < n; i++) get(qd, got[i]);
    sck = 1'b0;
    repeat (4) @(negedge mclk);
    cs_n = 1'b1;
    io_in = ~io_in;
    repeat (6) @(negedge mclk);
  endtask : xfer
endmodule : fir_host
`default_nettype wire

// ---- rtl/fir_cmd_reader.sv ----
// Serial flash command reader for identity, parameter table, serial number and register reads.
//
// Summary of operation
// RQ1 - Quad identity read needs four-line or quad mode.
// RQ2 - Host sends quad identity code on proper lines.
// RQ3 - Quad identity returns maker, two part bytes.
// RQ4 - Past identity undefined; chip select end stops driving.
// RQ5 - Table read: code, 3/4-byte address, latency dummies.
// RQ6 - Table bytes leave MSB first after dummies.
// RQ7 - Address picks the starting table byte.
// RQ8 - Continued clocking returns successive table bytes.
// RQ9 - Host keeps single-line table read under 133 MHz.
// RQ10 - Host should keep latency at eight; the bench also runs a four-line table read at latency two.
// RQ11 - Persistent latency is eight from factory.
// RQ12 - Four-line mode table read uses four lines.
// RQ13 - Serial read waits 32 dummy clocks.
// RQ14 - Data lines ignored during dummy clocks.
// RQ15 - Serial read returns eight fixed serial bytes.
// RQ16 - First status read works any time.
// RQ17 - Each further byte resamples the register.
// RQ18 - Host limits four-line status read rate.
// RQ19 - Second status read works any time, repeats.
// RQ20 - Host uses general read in four-line mode.
// RQ21 - Config reads return three registers, repeating.
// RQ22 - Refused quad identity leaves lines undriven.
`timescale 1ns/100ps
`default_nettype none
module fir_cmd_reader #(
  // Identity values; these defaults are arbitrary.
  parameter logic [7:0] MAKER_ID = 8'h3c,
  parameter logic [15:0] PART_ID = 16'h5a01,
  parameter logic [63:0] UNIQUE_SERIAL = 64'h0123_4567_89ab_cdef
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial link pins.
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n,
  // Volatile registers held elsewhere in the device.
  input wire logic [7:0] volatile_status_one,
  input wire logic [7:0] volatile_status_two,
  input wire logic [7:0] volatile_config_one,
  input wire logic [7:0] volatile_config_two,
  input wire logic [7:0] volatile_config_three,
  // Persistent latency setting.
  input wire logic pcfg3_load,
  input wire logic [7:0] pcfg3_data,
  output logic [7:0] persistent_config_three,
  // Parameter-table fetch port.
  output logic [31:0] ptab_addr,
  input wire logic ptab_valid,
  output logic ptab_ready,
  input wire logic [7:0] ptab_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and clock edge detection.

  logic [5:0] pins_sync;
  logic s_cs_n;
  logic s_sck;
  logic [3:0] s_io;
  logic sck_d;
  logic rise;
  logic fall;

  fir_sync #(.W(6), .RST(fir_pkg::SYNC_RST)) u_sync (
    .clk(mclk),
    .rst(sys_rst),
    .d({io_in, sck, cs_n}),
    .q(pins_sync)
  );

  assign s_cs_n = pins_sync[0];
  assign s_sck = pins_sync[1];
  assign s_io = pins_sync[5:2];

  // Delayed copy of the synchronised clock for edge finding.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= s_sck;
    end
  end

  // Edges only count inside a frame.
  assign rise = s_sck && !sck_d && !s_cs_n;
  assign fall = !s_sck && sck_d && !s_cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  logic four_line;
  logic quad_data;
  logic [5:0] addr_bits;
  logic [5:0] latency;

  assign four_line = volatile_config_two[fir_pkg::FOUR_LINE_POS];
  assign quad_data = volatile_config_one[fir_pkg::QUAD_DATA_POS];
  assign addr_bits = volatile_config_two[fir_pkg::ADDR_LEN_POS] ? fir_pkg::ADDR4_BITS : fir_pkg::ADDR3_BITS; // RQ5
  assign latency = {2'b00, volatile_config_three[fir_pkg::LAT_MSB:0]}; // RQ5

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer.

  fir_pkg::fir_state_t state;
  logic [5:0] cnt;
  logic [5:0] dummy_len;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [31:0] addr;
  logic [31:0] next_addr;
  logic cmd_done;
  logic addr_done;
  logic dummy_done;
  logic wide;
  logic fetch_on;

  // Instruction bits arrive on four lines only in four-line command mode.
  assign next_cmd = four_line ? {cmd[3:0], s_io} : {cmd[6:0], s_io[0]}; // RQ12
  assign next_addr = four_line ? {addr[27:0], s_io} : {addr[30:0], s_io[0]};
  assign cmd_done = (cnt + 6'h01) == fir_pkg::fir_clocks(fir_pkg::CMD_BITS, four_line);
  assign addr_done = (cnt + 6'h01) == fir_pkg::fir_clocks(addr_bits, four_line);
  assign dummy_done = (cnt + 6'h01) == dummy_len;

  // Phase walk on each rising clock edge; a high chip select aborts at once.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= fir_pkg::ST_CMD;
      cnt <= 6'h00;
      dummy_len <= 6'h00;
      cmd <= 8'h00;
      addr <= 32'h0000_0000;
      wide <= 1'b0;
    end else if (s_cs_n) begin
      state <= fir_pkg::ST_CMD; // RQ4
      cnt <= 6'h00;
      cmd <= 8'h00;
      addr <= 32'h0000_0000;
    end else if (rise) begin
      cnt <= cnt + 6'h01;
      unique case (state)
        fir_pkg::ST_CMD: begin
          cmd <= next_cmd;
          if (cmd_done) begin
            cnt <= 6'h00;
            wide <= four_line;
            unique case (next_cmd)
              fir_pkg::CMD_QUAD_ID: begin
                // Refused quad identity reads stay silent until chip select rises.
                if (four_line || quad_data) begin
                  state <= fir_pkg::ST_OUT; // RQ1
                  wide <= 1'b1; // RQ3
                end else begin
                  state <= fir_pkg::ST_SKIP; // RQ22
                end
              end
              fir_pkg::CMD_PTAB: begin
                state <= fir_pkg::ST_ADDR; // RQ5
              end
              fir_pkg::CMD_UID: begin
                state <= fir_pkg::ST_DUMMY;
                dummy_len <= fir_pkg::UID_DUMMY; // RQ13
              end
              fir_pkg::CMD_ST1, fir_pkg::CMD_ST2, fir_pkg::CMD_CF1, fir_pkg::CMD_CF2, fir_pkg::CMD_CF3: begin
                state <= fir_pkg::ST_OUT; // RQ16 RQ19 RQ21
              end
              default: begin
                state <= fir_pkg::ST_SKIP;
              end
            endcase
          end
        end
        fir_pkg::ST_ADDR: begin
          addr <= next_addr;
          if (addr_done) begin
            cnt <= 6'h00;
            dummy_len <= latency;
            state <= (latency == 6'h00) ? fir_pkg::ST_OUT : fir_pkg::ST_DUMMY; // RQ5
          end
        end
        fir_pkg::ST_DUMMY: begin
          // Lines are not looked at here, so a floating bus does no harm.
          if (dummy_done) begin
            cnt <= 6'h00; // RQ14
            state <= fir_pkg::ST_OUT;
          end
        end
        fir_pkg::ST_OUT, fir_pkg::ST_SKIP: begin
          cnt <= 6'h00;
        end
        default: begin
          state <= fir_pkg::ST_SKIP;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter-table prefetch.

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;
  logic ptab_take;

  assign ptab_ready = fetch_on && fifo_in_ready;
  assign ptab_take = ptab_valid && ptab_ready;

  // The address jumps to the host's start byte, then climbs one per byte fetched.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ptab_addr <= 32'h0000_0000;
      fetch_on <= 1'b0;
    end else if (s_cs_n) begin
      fetch_on <= 1'b0;
    end else if (rise && state == fir_pkg::ST_ADDR && addr_done) begin
      ptab_addr <= (addr_bits == fir_pkg::ADDR4_BITS) ? next_addr : {8'h00, next_addr[23:0]}; // RQ7
      fetch_on <= 1'b1;
    end else if (ptab_take) begin
      ptab_addr <= ptab_addr + 32'h0000_0001; // RQ8
    end
  end

  fir_fifo #(.W(fir_pkg::BYTE_W), .D(fir_pkg::FIFO_DEPTH)) u_fifo (
    .clk(mclk),
    .rst(sys_rst),
    .flush(s_cs_n),
    .in_valid(ptab_valid && fetch_on),
    .in_ready(fifo_in_ready),
    .in_data(ptab_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output shifter on falling clock edges.

  logic [2:0] out_cnt;
  logic [2:0] out_last;
  logic [3:0] byte_idx;
  logic [7:0] shreg;
  logic [7:0] next_byte;
  logic load;
  logic [7:0] next_shreg;
  logic drive;

  assign out_last = wide ? 3'h1 : 3'h7;
  assign load = fall && (state == fir_pkg::ST_OUT) && (out_cnt == 3'h0);
  assign fifo_pop = load && (cmd == fir_pkg::CMD_PTAB) && fifo_out_valid;
  assign next_shreg = load ? next_byte : (wide ? {shreg[3:0], 4'h0} : {shreg[6:0], 1'b0});

  // Byte source; registers are sampled at each byte start so repeats are fresh.
  always_comb begin
    next_byte = 8'h00;
    unique case (cmd)
      fir_pkg::CMD_QUAD_ID: begin
        if (byte_idx == 4'h0) begin
          next_byte = MAKER_ID; // RQ3
        end else if (byte_idx == 4'h1) begin
          next_byte = PART_ID[15:8];
        end else if (byte_idx < fir_pkg::ID_BYTES) begin
          next_byte = PART_ID[7:0];
        end
      end
      fir_pkg::CMD_UID: begin
        if (byte_idx < fir_pkg::UID_BYTES) begin
          next_byte = UNIQUE_SERIAL[8 * (7 - byte_idx[2:0]) +: 8]; // RQ15
        end
      end
      fir_pkg::CMD_PTAB: next_byte = fifo_out_data; // RQ6
      fir_pkg::CMD_ST1: next_byte = volatile_status_one; // RQ17
      fir_pkg::CMD_ST2: next_byte = volatile_status_two; // RQ19
      fir_pkg::CMD_CF1: next_byte = volatile_config_one; // RQ21
      fir_pkg::CMD_CF2: next_byte = volatile_config_two;
      fir_pkg::CMD_CF3: next_byte = volatile_config_three;
      default: next_byte = 8'h00;
    endcase
  end

  // Shift register, bit counter and byte index.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_cnt <= 3'h0;
      byte_idx <= 4'h0;
      shreg <= 8'h00;
    end else if (s_cs_n) begin
      out_cnt <= 3'h0;
      byte_idx <= 4'h0;
    end else if (fall && state == fir_pkg::ST_OUT) begin
      shreg <= next_shreg; // RQ6
      out_cnt <= (out_cnt == out_last) ? 3'h0 : out_cnt + 3'h1;
      if (load && byte_idx != 4'hf) begin
        byte_idx <= byte_idx + 4'h1; // RQ8
      end
    end
  end

  // Pin drivers; data leaves MSB first, on io1 alone or on all four lines.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      io_out <= 4'h0;
      io_oe_n <= fir_pkg::OE_OFF;
      drive <= 1'b0;
    end else if (s_cs_n || state != fir_pkg::ST_OUT) begin
      io_oe_n <= fir_pkg::OE_OFF; // RQ4 RQ22
      drive <= 1'b0;
    end else if (fall) begin
      io_out <= wide ? next_shreg[7:4] : {2'b00, next_shreg[7], 1'b0};
      io_oe_n <= wide ? fir_pkg::OE_QUAD : fir_pkg::OE_SINGLE; // RQ12
      drive <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Persistent latency setting.

  // Factory state shows eight dummy clocks; a later write may replace it.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      persistent_config_three <= fir_pkg::PCFG3_FACTORY; // RQ11
    end else if (pcfg3_load) begin
      persistent_config_three <= pcfg3_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_cmd_end;
    rise && state == fir_pkg::ST_CMD && cmd_done;
  endsequence

  sequence s_byte_load;
    load && !s_cs_n;
  endsequence

  property p_qid_gate;
    s_cmd_end ##0 (next_cmd == fir_pkg::CMD_QUAD_ID) |=>
      (state == ((four_line || quad_data) ? fir_pkg::ST_OUT : fir_pkg::ST_SKIP));
  endproperty
  a_qid_gate: assert property (p_qid_gate) else $error("quad identity gate wrong"); // RQ1

  property p_skip_quiet;
    state == fir_pkg::ST_SKIP |-> ##1 (io_oe_n == fir_pkg::OE_OFF);
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("refused command drives lines"); // RQ22

  property p_release;
    s_cs_n |=> (io_oe_n == fir_pkg::OE_OFF) && !drive;
  endproperty
  a_release: assert property (p_release) else $error("lines driven after frame end"); // RQ4

  property p_qid_wide;
    drive && cmd == fir_pkg::CMD_QUAD_ID |-> io_oe_n == fir_pkg::OE_QUAD;
  endproperty
  a_qid_wide: assert property (p_qid_wide) else $error("quad identity not on four lines"); // RQ3

  property p_msb_first;
    fall && state == fir_pkg::ST_OUT && out_cnt != 3'h0 && !wide && !s_cs_n |=> io_out[1] == $past(shreg[6]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("single-line bit order wrong"); // RQ6

  property p_uid_dummy;
    rise && state == fir_pkg::ST_DUMMY && cmd == fir_pkg::CMD_UID && !s_cs_n |->
      (dummy_len == fir_pkg::UID_DUMMY) ##1 ((state == fir_pkg::ST_OUT) == ($past(cnt) == 6'h1f));
  endproperty
  a_uid_dummy: assert property (p_uid_dummy) else $error("serial read latency wrong"); // RQ13

  property p_status_fresh;
    s_byte_load ##0 (cmd == fir_pkg::CMD_ST1) |=> shreg == $past(volatile_status_one);
  endproperty
  a_status_fresh: assert property (p_status_fresh) else $error("status byte not resampled"); // RQ17

  property p_ptab_step;
    ptab_take && !(rise && state == fir_pkg::ST_ADDR) && !s_cs_n |=> ptab_addr == $past(ptab_addr) + 32'h1;
  endproperty
  a_ptab_step: assert property (p_ptab_step) else $error("table address did not advance"); // RQ8

  property p_dummy_ignored;
    state == fir_pkg::ST_DUMMY && !s_cs_n |=> addr == $past(addr);
  endproperty
  a_dummy_ignored: assert property (p_dummy_ignored) else $error("dummy clocks changed address"); // RQ14

endmodule : fir_cmd_reader
`default_nettype wire

// ---- rtl/fir_fifo.sv ----
// Small valid/ready FIFO used to prefetch parameter-table bytes.
`timescale 1ns/100ps
`default_nettype none
module fir_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock, reset and frame flush.
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  // Full when pointers differ only in the wrap bit, empty when equal.
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Storage write.
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers; a flush empties the buffer at the end of a frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule : fir_fifo
`default_nettype wire

// ---- rtl/fir_pkg.sv ----
// Shared constants, types and helpers of the flash identity and register read block.
package fir_pkg;

  // Instruction codes served by this block.
  localparam logic [7:0] CMD_QUAD_ID = 8'haf;
  localparam logic [7:0] CMD_PTAB = 8'h5a;
  localparam logic [7:0] CMD_UID = 8'h4b;
  localparam logic [7:0] CMD_ST1 = 8'h05;
  localparam logic [7:0] CMD_ST2 = 8'h07;
  localparam logic [7:0] CMD_CF1 = 8'h35;
  localparam logic [7:0] CMD_CF2 = 8'h15;
  localparam logic [7:0] CMD_CF3 = 8'h33;

  // Field positions inside the configuration registers.
  localparam int FOUR_LINE_POS = 3;
  localparam int QUAD_DATA_POS = 1;
  localparam int ADDR_LEN_POS = 0;
  localparam int LAT_MSB = 3;

  // Phase lengths in bits, clocks or bytes.
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [5:0] UID_DUMMY = 6'h20;
  localparam logic [3:0] ID_BYTES = 4'h3;
  localparam logic [3:0] UID_BYTES = 4'h8;

  // Values after reset and output-enable patterns.
  localparam logic [7:0] PCFG3_FACTORY = 8'h08;
  localparam logic [5:0] SYNC_RST = 6'h01;
  localparam logic [3:0] OE_OFF = 4'hf;
  localparam logic [3:0] OE_QUAD = 4'h0;
  localparam logic [3:0] OE_SINGLE = 4'hd;

  // Parameter-table prefetch buffer shape.
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;

  // Command sequencer states.
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_OUT = 3'b011,
    ST_SKIP = 3'b100
  } fir_state_t;

  // Clocks needed for a field of the given bit count on one or four lines.
  function automatic logic [5:0] fir_clocks(input logic [5:0] bits, input logic quad);
    return quad ? {2'b00, bits[5:2]} : bits;
  endfunction : fir_clocks

endpackage : fir_pkg

// ---- rtl/fir_sync.sv ----
// Two-stage synchroniser for pins that arrive from outside the mclk domain.
`timescale 1ns/100ps
`default_nettype none
module fir_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Raw pins and their synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= RST;
      q <= RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : fir_sync
`default_nettype wire
